//--- verif/misc_config_monitor.sv
// Assertion checker for the configuration command block.
// Assumes it is bound to misc_config_block and sees only its ports.
`timescale 1ns/1ps
module misc_config_monitor (
	input wire logic        clock_in,
	input wire logic        rst_b_in,
	input wire logic        cmd_valid_in,
	input wire logic        cmd_write_in,
	input wire logic [7:0]  cmd_code_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic        cmd_pec_present_in,
	input wire logic        shutdown_event_in,
	input wire logic        fault_restart_in,
	input wire logic        fault_retry_mode_in,
	input wire logic        pwm_tick_in,
	input wire logic        pwm_fault_in,
	input wire logic [15:0] boot_voltage_in,
	input wire logic        rsp_valid_out,
	input wire logic [15:0] rsp_data_out,
	input wire logic        rsp_pec_error_out,
	input wire logic        rsp_data_error_out,
	input wire logic        rsp_cmd_error_out,
	input wire logic [6:0]  target_address_out,
	input wire logic [15:0] misc_options_word_out,
	input wire logic [15:0] settings_crc_out,
	input wire logic        settings_busy_out,
	input wire logic [15:0] vout_command_out,
	input wire logic [3:0]  fault_count_out,
	input wire logic [3:0]  telemetry_resolution_out,
	input wire logic        pin_reset_mode_out,
	input wire logic        pin_pullup_en_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// Mirrors lag one cycle behind commands
	wire mapped = cmd_valid_in && (cmd_code_in inside {8'hED, 8'hEE, 8'hEF, 8'hF0});
	wire rsv_hit = cmd_data_in[6:0] inside {7'h0C, 7'h28, 7'h37, 7'h61};
	wire [15:0] m = misc_options_word_out;

	pec_reject_a: assert property (mapped && !cmd_pec_present_in && m[15] && !$past(cmd_valid_in) |=> rsp_valid_out && rsp_pec_error_out)
		else $error("pec not refused");
	addr_reserved_a: assert property (mapped && cmd_write_in && cmd_code_in == 8'hEF && rsv_hit && cmd_pec_present_in |=> rsp_data_error_out ##1 $stable(target_address_out))
		else $error("reserved address taken");
	crc_write_a: assert property (mapped && cmd_write_in && cmd_code_in == 8'hF0 && cmd_pec_present_in |=> rsp_cmd_error_out && rsp_data_out == 16'h0000)
		else $error("crc write taken");
	addr_bit7_a: assert property (rsp_valid_out && $past(cmd_valid_in) && $past(cmd_code_in) == 8'hEF && !$past(cmd_write_in) |-> rsp_data_out[15:7] == 9'h000)
		else $error("address bit7 set");
	shutdown_reload_a: assert property (shutdown_event_in && m[14] && !$past(cmd_valid_in) && !settings_busy_out |=> vout_command_out == $past(boot_voltage_in))
		else $error("shutdown no reload");
	fault_reload_a: assert property (fault_restart_in && fault_retry_mode_in && m[13] && !$past(cmd_valid_in) && !settings_busy_out |=> vout_command_out == $past(boot_voltage_in))
		else $error("fault no reload");
	resolution_a: assert property (telemetry_resolution_out == 4'hC - {1'b0, m[1:0], 1'b0})
		else $error("resolution mismatch");
	pin_role_a: assert property (pin_reset_mode_out == m[12] && pin_pullup_en_out == (m[12] && !m[3]))
		else $error("pin role mismatch");
	fault_clear_a: assert property (pwm_tick_in && !pwm_fault_in && m[2] && !$past(cmd_valid_in) |=> fault_count_out == 4'h0)
		else $error("counter not cleared");
	fault_down_a: assert property (pwm_tick_in && !pwm_fault_in && !m[2] && fault_count_out != 4'h0 && !$past(cmd_valid_in) |=> fault_count_out == $past(fault_count_out) - 4'h1)
		else $error("no decrement");
	crc_hold_a: assert property (!settings_busy_out && !$past(settings_busy_out) |=> $stable(settings_crc_out))
		else $error("checksum moved idle");
endmodule : misc_config_monitor

bind misc_config_block misc_config_monitor mon_u (.*);

//--- verif/pmbus_host_model.sv
// Bus host issuing decoded commands and address queries.
// Assumes the block answers one cycle after it takes a request.
`timescale 1ns/1ps
module pmbus_host_model (
	input wire logic        clock_in,
	input wire logic        rsp_valid_in,
	input wire logic [15:0] rsp_data_in,
	input wire logic [2:0]  rsp_flags_in,
	input wire logic        addr_ack_in,
	output logic            cmd_valid_out,
	output logic            cmd_write_out,
	output logic [7:0]      cmd_code_out,
	output logic [15:0]     cmd_data_out,
	output logic            cmd_pec_present_out,
	output logic            addr_query_out,
	output logic [6:0]      addr_query_value_out,
	output logic            hang_out
);
	initial begin
		{cmd_valid_out, cmd_write_out, cmd_pec_present_out, addr_query_out, hang_out} = 5'h00;
		{cmd_code_out, cmd_data_out, addr_query_value_out} = 31'h00000000;
	end

	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
		input logic pec, output logic [15:0] rd, output logic [2:0] fl);
		int n;
		n = 0;
		@(negedge clock_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = wr;
		cmd_code_out = code;
		cmd_data_out = (code == 8'hED) ? (data & 16'hF00F) : data;
		cmd_pec_present_out = pec;
		@(negedge clock_in);
		cmd_valid_out = 1'b0;
		// Stale data inverted
		cmd_data_out = ~cmd_data_out;
		while (rsp_valid_in !== 1'b1 && n < 4) begin
			@(negedge clock_in);
			n++;
		end
		if (n == 4)
			hang_out = 1'b1;
		rd = rsp_data_in;
		fl = rsp_flags_in;
	endtask : xfer

	task automatic query(input logic [6:0] a, output logic ack);
		@(negedge clock_in);
		addr_query_out = 1'b1;
		addr_query_value_out = a;
		@(negedge clock_in);
		addr_query_out = 1'b0;
		addr_query_value_out = ~a;
		ack = addr_ack_in;
	endtask : query
endmodule : pmbus_host_model

//--- verif/tb_misc_config_block.sv
// Self-checking bench for the configuration command block.
// Assumes the host model drives commands; the bench the rest.
`timescale 1ns/1ps
module tb_misc_config_block;
	logic clock_in = 1'b0, rst_b_in = 1'b0, hang, ack;
	logic cmd_valid_in, cmd_write_in, cmd_pec_present_in, addr_query_in, addr_ack_out;
	logic nvm_store_done_in, nvm_restore_in, strap_address_valid_in, shutdown_event_in;
	logic fault_restart_in, fault_retry_mode_in, pwm_tick_in, pwm_fault_in, power_good_in;
	logic reset_assert_in, rsp_valid_out, rsp_pec_error_out, rsp_data_error_out, rsp_cmd_error_out;
	logic settings_busy_out, pin_reset_mode_out, pin_pullup_en_out;
	logic power_good_or_reset_pin_out, power_good_or_reset_pin_oe_out;
	logic [7:0] cmd_code_in;
	logic [6:0] addr_query_value_in, nvm_address_in, strap_address_in, target_address_out, na;
	logic [15:0] cmd_data_in, nvm_misc_in, nvm_override_in, boot_voltage_in, rsp_data_out;
	logic [15:0] misc_options_word_out, strap_override_word_out, settings_crc_out;
	logic [15:0] vout_command_out, rd, v, exp_vout, crc_old;
	logic [misc_config_pkg::NGRP-1:0][15:0] nvm_val_in, strap_val_in, setting_out, strap0;
	logic [misc_config_pkg::NGRP-1:0] setting_from_pin_out;
	logic [3:0] fault_count_out, telemetry_resolution_out;
	logic [2:0] fl;
	int errors = 0, check_count = 0;
	logic [6:0] rsv [4] = '{7'h0C, 7'h28, 7'h37, 7'h61};

	always #5 clock_in = ~clock_in;
	misc_config_block dut_u (.*);
	pmbus_host_model host_u (.clock_in(clock_in), .rsp_valid_in(rsp_valid_out),
		.rsp_data_in(rsp_data_out), .addr_ack_in(addr_ack_out), .hang_out(hang),
		.rsp_flags_in({rsp_pec_error_out, rsp_data_error_out, rsp_cmd_error_out}),
		.cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in), .cmd_code_out(cmd_code_in),
		.cmd_data_out(cmd_data_in), .cmd_pec_present_out(cmd_pec_present_in),
		.addr_query_out(addr_query_in), .addr_query_value_out(addr_query_value_in));

	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : check

	task automatic report_and_stop();
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	always @(posedge hang) begin
		check(1'b0, "no response");
		report_and_stop();
	end

	function automatic logic [15:0] crc_calc();
		logic [15:0] c, w;
		c = 16'h0000;
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? nvm_misc_in : (i == 1) ? nvm_override_in :
				(i == 2) ? {9'h000, nvm_address_in} : nvm_val_in[(i + 6) % 9];
			for (int b = 15; b >= 0; b--)
				c = (c[15] ^ w[b]) ? ({c[14:0], 1'b0} ^ 16'h8005) : {c[14:0], 1'b0};
		end
		return c;
	endfunction : crc_calc

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(negedge clock_in);
		while (settings_busy_out !== 1'b0 && n < 400) begin
			@(negedge clock_in);
			n++;
		end
		if (n == 400) begin
			check(1'b0, "load hang");
			report_and_stop();
		end
		@(negedge clock_in);
	endtask : wait_idle

	task automatic chk_groups(input logic [15:0] ovr);
		logic b;
		for (int g = 0; g < misc_config_pkg::NGRP; g++) begin
			b = ovr[misc_config_pkg::GRP_OVR_BIT[g]];
			check(setting_from_pin_out[g] === b, "group source");
			check(setting_out[g] === (b ? strap0[g] : nvm_val_in[g]), "group value");
		end
		exp_vout = ovr[0] ? strap0[0] : nvm_val_in[0];
		check(vout_command_out === exp_vout, "vout command");
	endtask : chk_groups

	task automatic tick(input logic f);
		@(negedge clock_in);
		pwm_tick_in = 1'b1;
		pwm_fault_in = f;
		@(negedge clock_in);
		pwm_tick_in = 1'b0;
	endtask : tick

	initial begin
		void'($urandom(64));
		{nvm_store_done_in, nvm_restore_in, strap_address_valid_in, shutdown_event_in} = 4'h0;
		{fault_restart_in, fault_retry_mode_in, pwm_tick_in, pwm_fault_in} = 4'h0;
		{power_good_in, reset_assert_in} = 2'h0;
		for (int g = 0; g < misc_config_pkg::NGRP; g++)
			{nvm_val_in[g], strap_val_in[g]} = {$urandom};
		strap0 = strap_val_in;
		nvm_misc_in = 16'($urandom) & 16'h700F;
		nvm_override_in = 16'($urandom) & 16'h1B2F;
		nvm_address_in = 7'h20 + 7'($urandom % 8);
		strap_address_in = 7'($urandom);
		boot_voltage_in = 16'($urandom);
		repeat (6) @(posedge clock_in);
		@(negedge clock_in) rst_b_in = 1'b1;
		wait_idle();
		chk_groups(nvm_override_in);
		check(target_address_out === nvm_address_in, "boot address");
		host_u.xfer(1'b0, 8'hF0, 16'h0000, 1'b0, rd, fl);
		check(rd === crc_calc() && fl === 3'b000, "boot checksum");
		for (int i = 0; i < 4; i++) begin
			v = (16'($urandom) & 16'h700C) | 16'(i);
			{power_good_in, reset_assert_in} = 2'($urandom);
			host_u.xfer(1'b1, 8'hED, v | 16'h0FF0, 1'b0, rd, fl);
			host_u.xfer(1'b0, 8'hED, 16'h0000, 1'b0, rd, fl);
			check(rd === v, "options rd");
			check(telemetry_resolution_out === 4'(12 - 2 * i), "resolution");
			check(pin_pullup_en_out === (v[12] & ~v[3]), "pullup");
			check(power_good_or_reset_pin_oe_out === (v[12] ? reset_assert_in : ~power_good_in), "pin");
			check(power_good_or_reset_pin_out === 1'b0, "pin level");
		end
		host_u.xfer(1'b1, 8'hED, 16'h8000, 1'b0, rd, fl);
		host_u.xfer(1'b1, 8'hED, 16'h0003, 1'b0, rd, fl);
		check(fl === 3'b100, "pec required");
		host_u.xfer(1'b0, 8'hED, 16'h0000, 1'b1, rd, fl);
		check(rd === 16'h8000, "pec kept");
		host_u.xfer(1'b1, 8'hED, 16'h0000, 1'b1, rd, fl);
		na = 7'h40 + 7'($urandom % 8);
		host_u.xfer(1'b1, 8'hEF, {9'h001, na}, 1'b1, rd, fl);
		host_u.query(na, ack);
		check(ack === 1'b1, "new address");
		host_u.query(nvm_address_in, ack);
		check(ack === 1'b0, "old address");
		foreach (rsv[i]) begin
			host_u.xfer(1'b1, 8'hEF, {9'h000, rsv[i]}, 1'b1, rd, fl);
			check(fl === 3'b010, "reserved address");
		end
		host_u.xfer(1'b0, 8'hEF, 16'h0000, 1'b1, rd, fl);
		check(rd === {9'h000, na}, "address readback");
		host_u.xfer(1'b1, 8'hF0, 16'h1234, 1'b1, rd, fl);
		check(fl === 3'b001, "checksum write");
		for (int i = 0; i < 8; i++) begin
			host_u.xfer(1'b1, 8'hED, 16'(i[1:0]) << 13, 1'b0, rd, fl);
			fault_retry_mode_in = 1'($urandom);
			boot_voltage_in = 16'($urandom);
			@(negedge clock_in);
			shutdown_event_in = i[2];
			fault_restart_in = ~i[2];
			@(negedge clock_in);
			{shutdown_event_in, fault_restart_in} = 2'h0;
			if (i[2] ? i[1] : (i[0] & fault_retry_mode_in))
				exp_vout = boot_voltage_in;
			check(vout_command_out === exp_vout, "vout reload");
		end
		host_u.xfer(1'b1, 8'hED, 16'h0000, 1'b0, rd, fl);
		repeat (3) tick(1'b1);
		tick(1'b0);
		check(fault_count_out === 4'h2, "count down");
		host_u.xfer(1'b1, 8'hED, 16'h0004, 1'b0, rd, fl);
		@(negedge clock_in);
		tick(1'b0);
		check(fault_count_out === 4'h0, "count clear");
		// Restore must reuse the boot strap sample
		strap_val_in = ~strap0;
		nvm_override_in = 16'($urandom) & 16'h1B2F;
		nvm_misc_in = 16'($urandom) & 16'h700F;
		@(negedge clock_in) nvm_restore_in = 1'b1;
		@(negedge clock_in) nvm_restore_in = 1'b0;
		wait_idle();
		chk_groups(nvm_override_in);
		check(misc_options_word_out === nvm_misc_in, "restored options");
		check(strap_override_word_out === nvm_override_in, "restored override");
		check(settings_crc_out === crc_calc(), "restore checksum");
		crc_old = crc_calc();
		for (int g = 0; g < misc_config_pkg::NGRP; g++)
			nvm_val_in[g] = 16'($urandom);
		repeat (20) @(negedge clock_in);
		check(settings_crc_out === crc_old, "checksum holds");
		@(negedge clock_in) nvm_store_done_in = 1'b1;
		@(negedge clock_in) nvm_store_done_in = 1'b0;
		wait_idle();
		check(settings_crc_out === crc_calc(), "store checksum");
		report_and_stop();
	end
endmodule : tb_misc_config_block

//--- verilog/misc_config_block.sv
// Miscellaneous configuration commands of a digital power converter.
// Assumes commands arrive already decoded, one-cycle valid, synchronous.
`timescale 1ns/1ps
module misc_config_block (
	input  wire logic                                   clock_in,
	input  wire logic                                   rst_b_in,
	input  wire logic                                   cmd_valid_in,
	input  wire logic                                   cmd_write_in,
	input  wire logic [7:0]                             cmd_code_in,
	input  wire logic [15:0]                            cmd_data_in,
	input  wire logic                                   cmd_pec_present_in,
	input  wire logic                                   addr_query_in,
	input  wire logic [6:0]                             addr_query_value_in,
	input  wire logic                                   nvm_store_done_in,
	input  wire logic                                   nvm_restore_in,
	input  wire logic [15:0]                            nvm_misc_in,
	input  wire logic [15:0]                            nvm_override_in,
	input  wire logic [6:0]                             nvm_address_in,
	input  wire logic                                   strap_address_valid_in,
	input  wire logic [6:0]                             strap_address_in,
	input  wire logic [misc_config_pkg::NGRP-1:0][15:0] nvm_val_in,
	input  wire logic [misc_config_pkg::NGRP-1:0][15:0] strap_val_in,
	input  wire logic [15:0]                            boot_voltage_in,
	input  wire logic                                   shutdown_event_in,
	input  wire logic                                   fault_restart_in,
	input  wire logic                                   fault_retry_mode_in,
	input  wire logic                                   pwm_tick_in,
	input  wire logic                                   pwm_fault_in,
	input  wire logic                                   power_good_in,
	input  wire logic                                   reset_assert_in,
	output logic                                        rsp_valid_out,
	output logic [15:0]                                 rsp_data_out,
	output logic                                        rsp_pec_error_out,
	output logic                                        rsp_data_error_out,
	output logic                                        rsp_cmd_error_out,
	output logic                                        addr_ack_out,
	output logic [6:0]                                  target_address_out,
	output logic [15:0]                                 misc_options_word_out,
	output logic [15:0]                                 strap_override_word_out,
	output logic [15:0]                                 settings_crc_out,
	output logic                                        settings_busy_out,
	output logic [misc_config_pkg::NGRP-1:0][15:0]      setting_out,
	output logic [misc_config_pkg::NGRP-1:0]            setting_from_pin_out,
	output logic [15:0]                                 vout_command_out,
	output logic [3:0]                                  fault_count_out,
	output logic [3:0]                                  telemetry_resolution_out,
	output logic                                        pin_reset_mode_out,
	output logic                                        pin_pullup_en_out,
	output logic                                        power_good_or_reset_pin_out,
	output logic                                        power_good_or_reset_pin_oe_out
);
	typedef enum logic [1:0] {ST_BOOT, ST_APPLY, ST_CRC, ST_IDLE} seq_state_t;

	seq_state_t  state;
	seq_state_t  next_state;
	logic [15:0] misc_options_word;
	logic [15:0] strap_override_word;
	logic [6:0]  bus_target_address;
	logic [15:0] settings_crc;
	logic [15:0] crc_acc;
	logic [3:0]  crc_word_idx;
	logic [3:0]  crc_bit_idx;
	logic [misc_config_pkg::NGRP-1:0][15:0] strap_latched;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire hit_misc   = cmd_code_in == misc_config_pkg::CMD_MISC_OPTIONS;
	wire hit_ovr    = cmd_code_in == misc_config_pkg::CMD_STRAP_OVR;
	wire hit_addr   = cmd_code_in == misc_config_pkg::CMD_TARGET_ADDR;
	wire hit_crc    = cmd_code_in == misc_config_pkg::CMD_SETTINGS_CRC;
	wire hit_any    = hit_misc | hit_ovr | hit_addr | hit_crc;
	wire pec_reject = misc_options_word[misc_config_pkg::MISC_PEC_REQ] &
		~cmd_pec_present_in;
	wire take       = cmd_valid_in & hit_any & ~pec_reject;
	wire wr_ok      = take & cmd_write_in;
	wire addr_rsvd  = cmd_data_in[6:0] inside {misc_config_pkg::RSV_ADDR_A,
		misc_config_pkg::RSV_ADDR_B, misc_config_pkg::RSV_ADDR_C,
		misc_config_pkg::RSV_ADDR_D};
	wire wr_misc    = wr_ok & hit_misc;
	wire wr_ovr     = wr_ok & hit_ovr;
	wire wr_addr    = wr_ok & hit_addr & ~addr_rsvd;
	wire wr_crc     = wr_ok & hit_crc;
	wire wr_badaddr = wr_ok & hit_addr & addr_rsvd;

	wire [15:0] read_mux = hit_misc ? misc_options_word :
		hit_ovr ? strap_override_word :
		hit_addr ? {9'h000, bus_target_address} :
		hit_crc ? settings_crc : 16'h0000;

	// ------------------------------------------------------------
	// Load sequencer
	// ------------------------------------------------------------
	wire boot_cycle  = state == ST_BOOT;
	wire apply_cycle = state == ST_APPLY;
	wire crc_run     = state == ST_CRC;
	wire crc_done    = crc_run & crc_word_idx == misc_config_pkg::CRC_LAST_WORD &
		crc_bit_idx == 4'h0;

	always_comb begin
		next_state = state;
		case (state)
			ST_BOOT:  next_state = ST_APPLY;
			ST_APPLY: next_state = ST_CRC;
			ST_CRC:   if (crc_done) next_state = ST_IDLE;
			ST_IDLE: begin
				if (nvm_restore_in) begin
					next_state = ST_APPLY;
				end else if (nvm_store_done_in) begin
					next_state = ST_CRC;
				end
			end
			default:  next_state = ST_BOOT;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// Restore reloads stored words first
	wire nvm_load = boot_cycle | (state == ST_IDLE & nvm_restore_in);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			misc_options_word <= 16'h0000;
			strap_override_word <= 16'h0000;
		end else begin
			if (wr_misc | nvm_load) misc_options_word <= wr_misc ? cmd_data_in : nvm_misc_in;
			if (wr_ovr | nvm_load) strap_override_word <= wr_ovr ? cmd_data_in : nvm_override_in;
		end
	end

	// Host write wins over a same-cycle restore; it is newer intent
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_target_address <= 7'h00;
		end else if (wr_addr) begin
			bus_target_address <= cmd_data_in[6:0];
		end else if (boot_cycle & strap_address_valid_in) begin
			bus_target_address <= strap_address_in;
		end else if (nvm_load) begin
			bus_target_address <= nvm_address_in;
		end
	end

	// ------------------------------------------------------------
	// Pin-strapped versus stored settings, one per group
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < misc_config_pkg::NGRP; g++) begin : g_grp
			wire use_pin = strap_override_word[misc_config_pkg::GRP_OVR_BIT[g]];
			always_ff @(posedge clock_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					strap_latched[g] <= 16'h0000;
					setting_out[g] <= 16'h0000;
					setting_from_pin_out[g] <= 1'b0;
				end else begin
					if (boot_cycle) begin
						strap_latched[g] <= strap_val_in[g];
					end
					if (apply_cycle) begin
						setting_out[g] <= use_pin ? strap_latched[g] : nvm_val_in[g];
						setting_from_pin_out[g] <= use_pin;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Output voltage command and boot voltage reload
	// ------------------------------------------------------------
	wire shdn_reload = shutdown_event_in &
		misc_options_word[misc_config_pkg::MISC_SHDN_RELOAD];
	wire flt_reload  = fault_restart_in & fault_retry_mode_in &
		misc_options_word[misc_config_pkg::MISC_FLT_RELOAD];
	wire vout_pin    = strap_override_word[misc_config_pkg::GRP_OVR_BIT[0]];

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			vout_command_out <= 16'h0000;
		end else if (apply_cycle) begin
			vout_command_out <= vout_pin ? strap_latched[misc_config_pkg::GRP_VOUT] :
				nvm_val_in[misc_config_pkg::GRP_VOUT];
		end else if (shdn_reload | flt_reload) begin
			vout_command_out <= boot_voltage_in;
		end
	end

	// ------------------------------------------------------------
	// Fault counter
	// ------------------------------------------------------------
	wire clr_mode = misc_options_word[misc_config_pkg::MISC_FLT_CLR_MODE];

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fault_count_out <= 4'h0;
		end else if (pwm_tick_in) begin
			if (pwm_fault_in) begin
				if (fault_count_out != misc_config_pkg::FAULT_COUNTER_CLEAR_MODE_MAX) begin
					fault_count_out <= fault_count_out + 4'h1;
				end
			end else if (clr_mode) begin
				fault_count_out <= 4'h0;
			end else if (fault_count_out != 4'h0) begin
				fault_count_out <= fault_count_out - 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Settings checksum, one bit per clock, msb first
	// ------------------------------------------------------------
	logic [15:0] crc_word;
	always_comb begin
		crc_word = 16'h0000;
		case (crc_word_idx)
			4'h0:    crc_word = misc_options_word;
			4'h1:    crc_word = strap_override_word;
			4'h2:    crc_word = {9'h000, bus_target_address};
			default: crc_word = nvm_val_in[crc_word_idx - 4'h3];
		endcase
	end

	wire        crc_fb   = crc_acc[15] ^ crc_word[crc_bit_idx];
	wire [15:0] crc_next = {crc_acc[14:0], 1'b0} ^
		(crc_fb ? misc_config_pkg::CRC_POLY : 16'h0000);

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			crc_acc <= misc_config_pkg::CRC_INIT;
			crc_word_idx <= 4'h0;
			crc_bit_idx <= 4'hF;
			settings_crc <= 16'h0000;
		end else if (crc_run) begin
			crc_acc <= crc_next;
			crc_bit_idx <= crc_bit_idx - 4'h1;
			if (crc_bit_idx == 4'h0) begin
				crc_word_idx <= crc_word_idx + 4'h1;
			end
			if (crc_done) begin
				settings_crc <= crc_next;
			end
		end else begin
			crc_acc <= misc_config_pkg::CRC_INIT;
			crc_word_idx <= 4'h0;
			crc_bit_idx <= 4'hF;
		end
	end

	// ------------------------------------------------------------
	// Command answers and address match
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 16'h0000;
			rsp_pec_error_out <= 1'b0;
			rsp_data_error_out <= 1'b0;
			rsp_cmd_error_out <= 1'b0;
		end else begin
			rsp_valid_out <= cmd_valid_in & hit_any;
			rsp_data_out <= take & ~cmd_write_in ? read_mux : 16'h0000;
			rsp_pec_error_out <= cmd_valid_in & hit_any & pec_reject;
			rsp_data_error_out <= wr_badaddr;
			rsp_cmd_error_out <= wr_crc;
		end
	end

	// Live register, so a rewrite moves the match at once
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_ack_out <= 1'b0;
		end else begin
			addr_ack_out <= addr_query_in &
				addr_query_value_in == bus_target_address;
		end
	end

	// ------------------------------------------------------------
	// Register mirrors, resolution and shared pin
	// ------------------------------------------------------------
	wire [1:0] res_field = misc_options_word[misc_config_pkg::MISC_RES_LSB +: 2];
	wire [3:0] res_bits  = res_field == misc_config_pkg::RES_12 ? misc_config_pkg::BITS_12 :
		res_field == misc_config_pkg::RES_10 ? misc_config_pkg::BITS_10 :
		res_field == misc_config_pkg::RES_8 ? misc_config_pkg::BITS_8 :
		misc_config_pkg::BITS_6;
	wire rst_mode  = misc_options_word[misc_config_pkg::MISC_RESET_MODE];
	wire pull_en   = rst_mode & ~misc_options_word[misc_config_pkg::MISC_PULLUP_DIS];
	// Open drain: pull low when not good; in reset mode, only when reset is asserted
	wire pin_low   = rst_mode ? reset_assert_in : ~power_good_in;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			target_address_out <= 7'h00;
			misc_options_word_out <= 16'h0000;
			strap_override_word_out <= 16'h0000;
			settings_crc_out <= 16'h0000;
			settings_busy_out <= 1'b1;
			telemetry_resolution_out <= misc_config_pkg::BITS_12;
			pin_reset_mode_out <= 1'b0;
			pin_pullup_en_out <= 1'b0;
			power_good_or_reset_pin_out <= 1'b0;
			power_good_or_reset_pin_oe_out <= 1'b1;
		end else begin
			target_address_out <= bus_target_address;
			misc_options_word_out <= misc_options_word;
			strap_override_word_out <= strap_override_word;
			settings_crc_out <= settings_crc;
			settings_busy_out <= next_state != ST_IDLE;
			telemetry_resolution_out <= res_bits;
			pin_reset_mode_out <= rst_mode;
			pin_pullup_en_out <= pull_en;
			power_good_or_reset_pin_out <= 1'b0;
			power_good_or_reset_pin_oe_out <= pin_low;
		end
	end
endmodule : misc_config_block

//--- verilog/misc_config_pkg.sv
// Constants for the converter's miscellaneous configuration commands.
// Assumes a PMBus transaction engine decodes frames and hands over commands.
package misc_config_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_MISC_OPTIONS = 8'hED;
	localparam logic [7:0] CMD_STRAP_OVR    = 8'hEE;
	localparam logic [7:0] CMD_TARGET_ADDR  = 8'hEF;
	localparam logic [7:0] CMD_SETTINGS_CRC = 8'hF0;

	// ------------------------------------------------------------
	// Options word fields
	// ------------------------------------------------------------
	localparam int MISC_PEC_REQ      = 15;
	localparam int MISC_SHDN_RELOAD  = 14;
	localparam int MISC_FLT_RELOAD   = 13;
	localparam int MISC_RESET_MODE   = 12;
	localparam int MISC_PULLUP_DIS   = 3;
	localparam int MISC_FLT_CLR_MODE = 2;
	localparam int MISC_RES_LSB      = 0;

	localparam logic [1:0] RES_12 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_8  = 2'h2;
	localparam logic [3:0] BITS_12 = 4'hC;
	localparam logic [3:0] BITS_10 = 4'hA;
	localparam logic [3:0] BITS_8  = 4'h8;
	localparam logic [3:0] BITS_6  = 4'h6;

	// ------------------------------------------------------------
	// Setting groups and their override bit positions
	// ------------------------------------------------------------
	localparam int NGRP = 9;
	// 0 vout,1 freq,2 iout oc,3 rise,4 phase_setting_a,5 follower,6 comp,7 sync,8 stack
	localparam logic [NGRP-1:0][3:0] GRP_OVR_BIT = {
		4'hC, 4'hB, 4'h9, 4'h8, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
	localparam int GRP_VOUT = 0;

	// ------------------------------------------------------------
	// Address and checksum
	// ------------------------------------------------------------
	localparam logic [6:0] RSV_ADDR_A = 7'h0C;
	localparam logic [6:0] RSV_ADDR_B = 7'h28;
	localparam logic [6:0] RSV_ADDR_C = 7'h37;
	localparam logic [6:0] RSV_ADDR_D = 7'h61;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam int CRC_WORDS = NGRP + 3;
	localparam logic [3:0] CRC_LAST_WORD = 4'hB;
	localparam logic [3:0] FAULT_COUNTER_CLEAR_MODE_MAX = 4'hF;
endpackage : misc_config_pkg
